// *** ocd_pkg.sv ***
// constants shared by the odd-ratio clock divider
package ocd_pkg;
   localparam int          CNT_W        = 3;
   localparam logic [2:0]  DIV_LOW      = 3'h3;
   localparam logic [2:0]  DIV_HIGH     = 3'h5;
   localparam logic        SEL_RESET    = 1'b1;
   localparam logic        GATE_RESET   = 1'b1;
   localparam logic        PHASE_RESET  = 1'b0;
   localparam logic [2:0]  CNT_RESET    = 3'h4;
   localparam int          SYNC_STAGES  = 2;
endpackage : ocd_pkg

// *** ocd_sync.sv ***
// two-flop synchroniser for one level input
module ocd_sync #(
   parameter logic RESET_VALUE = 1'b1
) (
   input  wire logic clk,     // divider input clock
   input  wire logic rst,     // async clear, active high
   input  wire logic din,     // asynchronous level
   output logic      dout     // synchronised level
);
   logic meta;

   // reset value stands in for the pin pull-up
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= RESET_VALUE;
         dout <= RESET_VALUE;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : ocd_sync

// *** ocd_divider.sv ***
// divide-by-three or divide-by-five clock divider with gate and clear
module ocd_divider
   import ocd_pkg::*;
(
   input  wire logic clk,                 // input clock, both edges used
   input  wire logic rst,                 // async reset, active high
   input  wire logic force_idle_clear_n,  // async clear pin, active low
   input  wire logic out_gate,            // output enable pin, high runs
   input  wire logic ratio_sel,           // low divide by 3, high by 5
   output logic      clk_out,             // divided clock, true
   output logic      clk_out_n            // divided clock, complement
);
   import ocd_pkg::*;

   logic             gate_s;
   logic             ratio_s;
   logic             ratio_r;
   logic [CNT_W-1:0] cnt;
   logic             rise_ph;
   logic             fall_ph;

   wire              clear_any = rst | ~force_idle_clear_n;

   function automatic logic [CNT_W-1:0] period_of(input logic sel);
      period_of = sel ? DIV_HIGH : DIV_LOW;
   endfunction : period_of

   // high phase of the rising-edge copy: (ratio + 1) / 2 cycles
   function automatic logic [CNT_W-1:0] high_len(input logic sel);
      logic [CNT_W-1:0] p;
      p        = period_of(sel);
      high_len = (p >> 1) + 3'h1;
   endfunction : high_len

   ocd_sync #(
      .RESET_VALUE (GATE_RESET)
   ) u_gate_sync (
      .clk  (clk),
      .rst  (clear_any),
      .din  (out_gate),
      .dout (gate_s)
   );

   ocd_sync #(
      .RESET_VALUE (SEL_RESET)
   ) u_sel_sync (
      .clk  (clk),
      .rst  (clear_any),
      .din  (ratio_sel),
      .dout (ratio_s)
   );

   wire [CNT_W-1:0] last_cnt   = period_of(ratio_r) - 3'h1;
   wire             wrap       = (cnt == last_cnt);
   // ratio switches only at a period boundary or while gated off, so no runt cycle appears
   wire             next_ratio = (wrap || !gate_s) ? ratio_s : ratio_r;
   wire [CNT_W-1:0] next_last  = period_of(next_ratio) - 3'h1;
   // gate off parks the counter on the last count, phase low
   wire [CNT_W-1:0] next_cnt   = !gate_s ? next_last :
                                 (wrap ? 3'h0 : cnt + 3'h1);
   wire             next_rise  = (next_cnt < high_len(next_ratio));

   always_ff @(posedge clk or posedge clear_any) begin
      if (clear_any) begin
         ratio_r <= SEL_RESET;
         cnt     <= CNT_RESET;
         rise_ph <= PHASE_RESET;
      end else begin
         ratio_r <= next_ratio;
         cnt     <= next_cnt;
         rise_ph <= next_rise;
      end
   end

   // half-cycle delayed copy; and-ing trims the odd half cycle
   always_ff @(negedge clk or posedge clear_any) begin
      if (clear_any) begin
         fall_ph <= PHASE_RESET;
      end else begin
         fall_ph <= rise_ph;
      end
   end

   // both phase flops clear asynchronously, so clear acts with no edge
   assign clk_out   = rise_ph & fall_ph;
   assign clk_out_n = ~clk_out;

   a_out_compl: assert property (
      @(posedge clk) clk_out_n == !clk_out
   ) else $error("complement output is not the inverse");

   a_out_compl_fall: assert property (
      @(negedge clk) disable iff (clear_any)
      ($past(clk_out_n) == !$past(clk_out)) && (clk_out_n != clk_out)
   ) else $error("complement output mismatch at falling edge");

   a_clear_idle: assert property (
      @(posedge clk) !force_idle_clear_n |-> !clk_out && clk_out_n
   ) else $error("clear did not force idle outputs");

   a_default_high: assert property (
      @(posedge clk) $fell(clear_any) |-> gate_s && ratio_s && ratio_r
   ) else $error("controls do not default to enabled divide by five");

   a_gate_hold: assert property (
      @(posedge clk) disable iff (clear_any)
      (!gate_s && $past(!gate_s)) |-> !clk_out && clk_out_n && !rise_ph
   ) else $error("gated-off output not idle");

   a_gate_latency: assert property (
      @(posedge clk) disable iff (clear_any)
      !gate_s |=> !clk_out
   ) else $error("gate off not seen after rising and falling edge");

   a_gate_start: assert property (
      @(posedge clk) disable iff (clear_any)
      ($rose(gate_s) && $past(!gate_s, 2)) |-> !clk_out ##1 clk_out
   ) else $error("output not started one rise and fall after gate");

   a_half_shift: assert property (
      @(posedge clk) disable iff (clear_any)
      $past(!clear_any) |-> (fall_ph == rise_ph)
   ) else $error("falling-edge phase not half a cycle behind");

   a_div3_shape: assert property (
      @(posedge clk) disable iff (clear_any)
      (gate_s && !ratio_r && $rose(rise_ph)) ##1 gate_s [*2]
      |-> ($past(rise_ph) && !rise_ph) ##1 rise_ph
   ) else $error("divide by three waveform wrong");

   a_div5_shape: assert property (
      @(posedge clk) disable iff (clear_any)
      (gate_s && ratio_r && $rose(rise_ph)) ##1 gate_s [*4]
      |-> ($past(rise_ph, 3) && $past(rise_ph, 2) && !$past(rise_ph)
           && !rise_ph) ##1 rise_ph
   ) else $error("divide by five waveform wrong");

   a_sel_taken: assert property (
      @(posedge clk) disable iff (clear_any)
      (wrap && gate_s) |=> ratio_r == $past(ratio_s)
   ) else $error("ratio select not taken at period boundary");

   // counter and sync checks; sampled signal values only, no helper state
   a_cnt_range: assert property (
      @(posedge clk) disable iff (clear_any)
      cnt <= last_cnt
   ) else $error("counter beyond last count of period");

   a_park_last: assert property (
      @(posedge clk) disable iff (clear_any)
      !gate_s
      |=> (cnt == last_cnt) && !rise_ph
   ) else $error("gated counter not parked on last count");

   // pins are async, so the two flops stretch the gate latency
   a_gate_sync: assert property (
      @(posedge clk) disable iff (clear_any)
      $past(!clear_any) && $past(!clear_any, 2)
      |-> gate_s == $past(out_gate, 2)
   ) else $error("gate pin not seen after two flops");

   a_sel_sync: assert property (
      @(posedge clk) disable iff (clear_any)
      $past(!clear_any) && $past(!clear_any, 2)
      |-> ratio_s == $past(ratio_sel, 2)
   ) else $error("ratio pin not seen after two flops");

   a_ratio_hold: assert property (
      @(posedge clk) disable iff (clear_any)
      gate_s && !wrap
      |=> $stable(ratio_r)
   ) else $error("ratio changed inside a period");

   a_wrap_zero: assert property (
      @(posedge clk) disable iff (clear_any)
      gate_s && wrap
      |=> (cnt == '0) && rise_ph
   ) else $error("period did not restart after last count");

   a_rise_start: assert property (
      @(posedge clk) disable iff (clear_any)
      $rose(rise_ph)
      |-> cnt == '0
   ) else $error("high phase began away from count zero");

   a_rise_end: assert property (
      @(posedge clk) disable iff (clear_any)
      $past(gate_s) && $fell(rise_ph)
      |-> cnt == high_len(ratio_r)
   ) else $error("high phase length wrong for ratio");

   a_reset_idle: assert property (
      @(posedge clk)
      clear_any
      |-> !clk_out && clk_out_n
   ) else $error("outputs not idle during clear or reset");

   a_start_default: assert property (
      @(posedge clk) disable iff (clear_any)
      $fell(clear_any)
      |-> !rise_ph ##1 rise_ph
   ) else $error("output did not start after clear release");

   a_fall_follow: assert property (
      @(negedge clk) disable iff (clear_any)
      $past(!clear_any)
      |-> fall_ph == $past(rise_ph)
   ) else $error("falling-edge copy not one half cycle late");

   a_gated_fall: assert property (
      @(negedge clk) disable iff (clear_any)
      $past(!gate_s) && $past(!gate_s, 2)
      |-> !fall_ph && !clk_out && clk_out_n
   ) else $error("falling-edge phase active while gated");
endmodule : ocd_divider

// *** ocd_clk_src.sv ***
// clock source model standing in for the differential input pair
module ocd_clk_src (
   output logic clk   // divider input clock, free running
);
   timeunit 1ns;
   timeprecision 100ps;
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
endmodule : ocd_clk_src

// *** tb_top.sv ***
// self-checking bench for the odd-ratio clock divider
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ocd_pkg::*;
   logic    clk;
   logic    rst;
   logic    clr_n;
   logic    gate;
   logic    sel;
   logic    q;
   logic    qn;
   int      err_total;
   int      checks;
   int      cyc;
   realtime t0, t1, t2;
   ocd_clk_src src_u (.clk(clk));
   ocd_divider dut_u (.clk(clk), .rst(rst), .force_idle_clear_n(clr_n),
      .out_gate(gate), .ratio_sel(sel), .clk_out(q), .clk_out_n(qn));
   task automatic summarize;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic cmp_bit(string nm, logic e, logic g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s exp %b got %b", nm, e, g);
      end
   endtask : cmp_bit
   task automatic cmp_time(string nm, realtime e, realtime g);
      checks++;
      if (g != e) begin
         err_total++;
         $display("wrong value %s exp %0t got %0t", nm, e, g);
      end
   endtask : cmp_time
   // settle several periods so a deferred ratio change has landed
   task automatic t_ratio(logic s, int n, int lo, int hi);
      @(posedge clk) sel <= s;
      repeat (4 * n) @(posedge clk);
      @(posedge q) t0 = $realtime;
      @(negedge q) t1 = $realtime;
      #0.1 cmp_bit("complement", 1'b1, qn);
      @(posedge q) t2 = $realtime;
      cmp_time("period", 5.0 * n, t2 - t0);
      cmp_bit("duty", 1'b1, (t1 - t0) * 100 >= lo * (t2 - t0)
         && (t1 - t0) * 100 <= hi * (t2 - t0));
      $display("test ratio %0d done", n);
   endtask : t_ratio
   task automatic t_gate(logic s);
      @(posedge clk) begin
         sel  <= s;
         gate <= 1'b0;
      end
      repeat (12) @(posedge clk);
      cmp_bit("gated q", 1'b0, q);
      cmp_bit("gated qn", 1'b1, qn);
      gate <= 1'b1;
      // two sync flops, then one rising and one falling edge
      repeat (2) @(posedge clk);
      @(negedge clk) #0.1 cmp_bit("gate latency", 1'b0, q);
      @(negedge clk) #0.1 cmp_bit("gate start", 1'b1, q);
      $display("test gate sel %b done", s);
   endtask : t_gate
   // clear lands mid-high, so only the async path can drop q
   task automatic t_clear;
      @(posedge q);
      @(posedge clk) clr_n <= 1'b0;
      #1 cmp_bit("clear q", 1'b0, q);
      cmp_bit("clear qn", 1'b1, qn);
      repeat (3) @(posedge clk);
      cmp_bit("clear hold", 1'b0, q);
      clr_n <= 1'b1;
      $display("test clear done");
   endtask : t_clear
   initial begin
      // nba so the reset edge is not lost in the time-zero race
      rst <= 1'b1;
      clr_n = 1'b1;
      gate = 1'b1;
      sel = 1'b1;
      err_total = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_ratio(1'b1, 5, 47, 53);
      t_ratio(1'b0, 3, 45, 55);
      t_gate(1'b0);
      t_gate(1'b1);
      t_ratio(1'b1, 5, 47, 53);
      t_clear();
      t_ratio(1'b0, 3, 45, 55);
      summarize();
   end
   // cap well above the fewer than two hundred cycles the tests need
   initial cyc = 0;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end
endmodule : tb_top
